// ---- pam_pkg.sv ----
package pam_pkg;
  localparam int          ADDR_W         = 16;
  localparam int          DATA_W         = 18;
  localparam int          BYTE_W         = 9;
  localparam int          SYNC_STAGES    = 2;
  localparam int          WRAP_PULSE_CYC = 1;
  localparam logic [15:0] CNT_RST_VAL    = 16'h0000;
  localparam logic [15:0] MASK_RST_VAL   = 16'hFFFF;
  localparam logic [17:0] DQ_RST_VAL     = 18'h0_0000;

  // what the address pins carry in the current cycle
  typedef enum logic [1:0] {
    PAM_AD_IN   = 2'b00,
    PAM_AD_CNT  = 2'b01,
    PAM_AD_MASK = 2'b10
  } pam_addr_src_t;
endpackage : pam_pkg

// ---- pam_dq_if.sv ----
`timescale 1ns/10ps
interface pam_dq_if #(
  parameter int DW = pam_pkg::DATA_W
);
  logic          rd_stb;
  logic [1:0]    rd_be;
  logic [DW-1:0] rd_data;
  logic          clr;

  modport src (output rd_stb, output rd_be, output rd_data, output clr);
  modport drv (input rd_stb, input rd_be, input rd_data, input clr);
endinterface : pam_dq_if

// ---- pam_sync2.sv ----
`timescale 1ns/10ps
module pam_sync2 #(
  parameter int         W       = 1,
  parameter logic [0:0] RST_VAL = 1'b1
) (
  input  wire logic         clk,     // port clock
  input  wire logic         sys_rst, // synchronous reset
  input  wire logic [W-1:0] d,       // asynchronous level
  output logic      [W-1:0] q        // level in clk domain
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pam_sync_st_t;

  pam_sync_st_t st_q;
  pam_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{s1: {W{RST_VAL}}, s2: {W{RST_VAL}}};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule : pam_sync2

// ---- pam_dq_drive.sv ----
`timescale 1ns/10ps
module pam_dq_drive #(
  parameter int DW = pam_pkg::DATA_W,
  parameter int BW = pam_pkg::BYTE_W
) (
  input  wire logic          clk,             // port clock
  input  wire logic          sys_rst,         // synchronous reset
  input  wire logic          output_enable_n, // raw pin, async gate
  pam_dq_if.drv              link,            // read word from the port core
  output logic      [DW-1:0] dq_o,            // data pins out
  output logic      [1:0]    dq_oe            // [0] lower, [1] upper byte
);
  typedef struct packed {
    logic [DW-1:0] dq;
    logic [1:0]    be;
    logic          live;
  } pam_dq_st_t;

  pam_dq_st_t st_q;
  pam_dq_st_t st_d;

  always_comb begin
    st_d      = st_q;
    st_d.live = link.rd_stb & ~link.clr;
    if (link.rd_stb) begin
      st_d.dq = link.rd_data;
      st_d.be = link.rd_be;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '{dq: pam_pkg::DQ_RST_VAL, be: 2'h0, live: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign dq_o = st_q.dq;
  // no clock in this path: the pin gates the drivers at once
  assign dq_oe = st_q.be & {2{st_q.live & ~output_enable_n}};
endmodule : pam_dq_drive

// ---- pam_port.sv ----
`timescale 1ns/10ps
module pam_port #(
  parameter int AW = pam_pkg::ADDR_W,
  parameter int DW = pam_pkg::DATA_W
) (
  input  wire logic          clk,                 // port clock
  input  wire logic          sys_rst,             // synchronous reset
  input  wire logic          global_reset_n,      // asynchronous master reset
  input  wire logic          select_low_active,   // chip enable, active low
  input  wire logic          select_high_active,  // chip enable, active high
  input  wire logic          read_write,          // 1 read, 0 write
  input  wire logic          lower_byte_select_n, // lower byte enable
  input  wire logic          upper_byte_select_n, // upper byte enable
  input  wire logic          output_enable_n,     // async data output enable
  input  wire logic          counter_load_n,      // load counter from pins
  input  wire logic          counter_increment_n, // advance counter
  input  wire logic          counter_readback_n,  // counter onto address pins
  input  wire logic          counter_clear_n,     // zero the counter
  input  wire logic          mask_load_n,         // load mask from pins
  input  wire logic          mask_readback_n,     // mask onto address pins
  input  wire logic [AW-1:0] addr_i,              // address pins in
  output logic      [AW-1:0] addr_o,              // address pins out
  output logic               addr_oe,             // address pins driven
  input  wire logic [DW-1:0] dq_i,                // data pins in
  output logic      [DW-1:0] dq_o,                // data pins out
  output logic      [1:0]    dq_oe,               // data byte drivers
  output logic               wrap_interrupt_n,    // wrap flag, active low
  output logic      [AW-1:0] mem_addr,            // array address
  output logic               mem_rd,              // array read strobe
  output logic               mem_wr,              // array write strobe
  output logic      [1:0]    mem_be,              // array byte enables
  output logic      [DW-1:0] mem_wdata,           // array write data
  input  wire logic [DW-1:0] mem_rdata            // word, cycle after mem_rd
);

  typedef struct packed {
    logic [AW-1:0]         cnt;
    logic [AW-1:0]         mask;
    pam_pkg::pam_addr_src_t src;
    logic [AW-1:0]         addr_out;
    logic                  wrap;
    logic [AW-1:0]         maddr;
    logic                  mrd;
    logic                  mwr;
    logic [1:0]            mbe;
    logic [DW-1:0]         mwdata;
    logic                  rd_stb;
    logic [1:0]            rd_be;
  } pam_port_st_t;

  localparam pam_port_st_t PAM_ST_RST = '{
    cnt:      pam_pkg::CNT_RST_VAL[AW-1:0],
    mask:     pam_pkg::MASK_RST_VAL[AW-1:0],
    src:      pam_pkg::PAM_AD_IN,
    addr_out: '0,
    wrap:     1'b0,
    maddr:    '0,
    mrd:      1'b0,
    mwr:      1'b0,
    mbe:      2'h0,
    mwdata:   '0,
    rd_stb:   1'b0,
    rd_be:    2'h0
  };

  pam_port_st_t st_q;
  pam_port_st_t st_d;

  logic greset_n_s;
  logic master_clr;
  logic selected;
  logic do_clear;
  logic do_load;
  logic do_inc;
  logic at_top;
  logic [AW-1:0] cnt_step;
  logic [AW-1:0] access_addr;
  logic [1:0]    byte_en;

  pam_dq_if #(.DW(DW)) dq_link ();

  // masked step: cleared mask bits hold, set bits form the counting field
  function automatic logic [AW-1:0] pam_step(
    input logic [AW-1:0] c,
    input logic [AW-1:0] m
  );
    logic [AW-1:0] s;
    s = (c | ~m) + {{(AW-1){1'b0}}, 1'b1};
    return (c & ~m) | (s & m);
  endfunction : pam_step

  // the master reset pin is asynchronous to clk, so bring it in first
  pam_sync2 #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_greset_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       (global_reset_n),
    .q       (greset_n_s)
  );

  assign master_clr = ~greset_n_s;

  assign selected = ~select_low_active & select_high_active;

  // clear beats load beats step; the master keeps these apart anyway
  assign do_clear = ~counter_clear_n;
  assign do_load  = counter_clear_n & ~counter_load_n;
  assign do_inc   = counter_clear_n & counter_load_n & ~counter_increment_n;

  assign cnt_step = pam_step(st_q.cnt, st_q.mask);
  assign at_top   = (st_q.cnt & st_q.mask) == st_q.mask;

  assign byte_en = ~{upper_byte_select_n, lower_byte_select_n};

  // which address the array sees for an access in this cycle
  always_comb begin
    if (!mask_readback_n) begin
      access_addr = addr_i;
    end else if (!counter_readback_n) begin
      access_addr = st_q.cnt;
    end else if (do_load) begin
      access_addr = addr_i;
    end else begin
      access_addr = st_q.cnt;
    end
  end

  always_comb begin
    st_d = st_q;

    // counter
    if (do_clear) begin
      st_d.cnt = pam_pkg::CNT_RST_VAL[AW-1:0];
    end else if (do_load) begin
      st_d.cnt = addr_i;
    end else if (do_inc) begin
      st_d.cnt = cnt_step;
    end

    // wrap pulse lives exactly one cycle unless wrapping again
    st_d.wrap = do_inc & at_top;

    // mask register
    if (!mask_load_n) begin
      st_d.mask = addr_i;
    end

    // address pin drive, chip enables deliberately ignored
    case ({counter_readback_n, mask_readback_n})
      2'b01: begin
        st_d.src = pam_pkg::PAM_AD_CNT;
      end
      2'b10: begin
        st_d.src = pam_pkg::PAM_AD_MASK;
      end
      default: begin
        st_d.src = pam_pkg::PAM_AD_IN;
      end
    endcase

    case (st_d.src)
      pam_pkg::PAM_AD_CNT: begin
        st_d.addr_out = st_q.cnt;
      end
      pam_pkg::PAM_AD_MASK: begin
        st_d.addr_out = st_q.mask;
      end
      default: begin
        st_d.addr_out = st_q.addr_out;
      end
    endcase

    // array access, only while the port is selected
    st_d.mrd    = selected & read_write;
    st_d.mwr    = selected & ~read_write & (byte_en != 2'h0);
    st_d.maddr  = access_addr;
    st_d.mbe    = byte_en;
    st_d.mwdata = dq_i;

    // word arrives the cycle after the strobe, then goes to the pins
    st_d.rd_stb = st_q.mrd;
    st_d.rd_be  = st_q.mbe;

    if (master_clr) begin
      st_d = PAM_ST_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= PAM_ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign dq_link.rd_stb  = st_q.rd_stb;
  assign dq_link.rd_be   = st_q.rd_be;
  assign dq_link.rd_data = mem_rdata;
  assign dq_link.clr     = master_clr;

  pam_dq_drive #(
    .DW (DW),
    .BW (pam_pkg::BYTE_W)
  ) u_dq_drive (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .output_enable_n (output_enable_n),
    .link            (dq_link),
    .dq_o            (dq_o),
    .dq_oe           (dq_oe)
  );

  assign addr_o = st_q.addr_out;

  // the raw pin releases the address pins and the flag at once; the
  // synchronised copy then clears the stored state a few cycles later
  assign addr_oe = (st_q.src != pam_pkg::PAM_AD_IN) & global_reset_n;

  assign wrap_interrupt_n = ~(st_q.wrap & global_reset_n);

  assign mem_addr  = st_q.maddr;
  assign mem_rd    = st_q.mrd;
  assign mem_wr    = st_q.mwr;
  assign mem_be    = st_q.mbe;
  assign mem_wdata = st_q.mwdata;
endmodule : pam_port

// ---- pam_mem_model.sv ----
`timescale 1ns/10ps
module pam_mem_model (
  input  wire logic        clk,      // port clock
  input  wire logic        mem_rd,   // read strobe
  input  wire logic [15:0] mem_addr, // word address
  output logic      [17:0] mem_rdata // word, cycle after strobe
);
  // each word is its address tagged 2'b10, so no storage is needed;
  // between reads the bus toggles so a stale word cannot pass
  always_ff @(posedge clk) begin
    if (mem_rd) begin
      mem_rdata <= {2'b10, mem_addr};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : pam_mem_model

// ---- pam_port_monitor.sv ----
`timescale 1ns/10ps
module pam_port_monitor (
  input wire logic        clk,                 // clock
  input wire logic        sys_rst,             // reset
  input wire logic        global_reset_n,      // master reset
  input wire logic        select_low_active,   // enable
  input wire logic        select_high_active,  // enable
  input wire logic        read_write,          // 1 read
  input wire logic        output_enable_n,     // oe
  input wire logic        counter_load_n,      // ctl
  input wire logic        counter_increment_n, // ctl
  input wire logic        counter_readback_n,  // ctl
  input wire logic        counter_clear_n,     // ctl
  input wire logic        mask_load_n,         // ctl
  input wire logic        mask_readback_n,     // ctl
  input wire logic [15:0] addr_i,              // pins in
  input wire logic [15:0] addr_o,              // pins out
  input wire logic        addr_oe,             // pins driven
  input wire logic [1:0]  dq_oe,               // data drivers
  input wire logic        wrap_interrupt_n,    // wrap flag
  input wire logic [15:0] mem_addr,            // array address
  input wire logic        mem_rd,              // array read
  input wire logic        mem_wr               // array write
);
  logic [2:0] gr_q;
  // state lags the raw master reset by the synchroniser
  wire        gok = &gr_q && global_reset_n;
  wire        sel = !select_low_active && select_high_active;
  wire        quiet = &{counter_load_n, counter_increment_n, counter_clear_n, mask_load_n,
                        counter_readback_n, mask_readback_n};
  wire        rbc = counter_load_n && counter_increment_n && counter_clear_n && mask_load_n &&
                    !counter_readback_n && mask_readback_n;
  always_ff @(posedge clk) begin
    gr_q <= {gr_q[1:0], global_reset_n};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  oe_gate_a: assert property (output_enable_n |-> dq_oe == 2'b00)
    else $error("data driven with output enable high");
  rb_drive_a: assert property (
    (gok && counter_readback_n != mask_readback_n) |=> (addr_oe || !global_reset_n))
    else $error("readback did not drive address pins");
  rb_release_a: assert property ((counter_readback_n == mask_readback_n) |=> !addr_oe)
    else $error("address pins driven without readback");
  clr_zero_a: assert property (
    (gok && !counter_clear_n) ##1 quiet ##1 rbc |=> addr_o == 16'h0000)
    else $error("counter not zero after clear");
  wrap_cause_a: assert property (!wrap_interrupt_n |-> $past(counter_increment_n) == 1'b0)
    else $error("wrap flag without increment");
  wrap_once_a: assert property (
    $fell(wrap_interrupt_n) && counter_increment_n |=> wrap_interrupt_n)
    else $error("wrap flag longer than one cycle");
  global_reset_n_gate_a: assert property (!global_reset_n |-> wrap_interrupt_n && !addr_oe)
    else $error("outputs active during master reset");
  desel_idle_a: assert property (!sel |=> !mem_rd && !mem_wr)
    else $error("array access while deselected");
  cnt_rd_a: assert property (
    (gok && sel && read_write && rbc) |=> mem_rd && mem_addr == addr_o)
    else $error("readback read not at counter");
  mask_rd_a: assert property (
    (gok && sel && read_write && !mask_readback_n && counter_readback_n)
      |=> mem_rd && mem_addr == $past(addr_i))
    else $error("mask readback read not at pin address");
endmodule : pam_port_monitor
bind pam_port pam_port_monitor pam_port_monitor_inst (.clk, .sys_rst, .global_reset_n,
  .select_low_active, .select_high_active, .read_write, .output_enable_n, .counter_load_n,
  .counter_increment_n, .counter_readback_n, .counter_clear_n, .mask_load_n,
  .mask_readback_n, .addr_i, .addr_o, .addr_oe, .dq_oe, .wrap_interrupt_n, .mem_addr,
  .mem_rd, .mem_wr);

// ---- tb_top.sv ----
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  localparam logic [5:0] LD = 6'h01, INC = 6'h02, CRB = 6'h04, CLR = 6'h08, MLD = 6'h10;
  localparam logic [5:0] MRB = 6'h20;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        global_reset_n = 1'b1;
  logic        select_low_active = 1'b1;
  logic        select_high_active = 1'b0;
  logic        read_write = 1'b1;
  logic [1:0]  be_n = 2'b11;
  logic        oe_n = 1'b1;
  logic [5:0]  ctl_n = 6'h3f;
  logic [15:0] addr_i = 16'h0000;
  logic [17:0] dq_i = 18'h0_0000;
  logic [15:0] addr_o, mem_addr;
  logic [17:0] dq_o, mem_rdata, mem_wdata;
  logic [1:0]  dq_oe, mem_be;
  logic        addr_oe, wrap_interrupt_n, mem_rd, mem_wr;
  int          n_fail = 0, check_count = 0, cycles = 0;
  pam_port pam_port_inst (.clk, .sys_rst, .global_reset_n, .select_low_active,
    .select_high_active, .read_write, .lower_byte_select_n (be_n[0]),
    .upper_byte_select_n (be_n[1]), .output_enable_n (oe_n), .counter_load_n (ctl_n[0]),
    .counter_increment_n (ctl_n[1]), .counter_readback_n (ctl_n[2]),
    .counter_clear_n (ctl_n[3]), .mask_load_n (ctl_n[4]), .mask_readback_n (ctl_n[5]),
    .addr_i, .addr_o, .addr_oe, .dq_i, .dq_o, .dq_oe, .wrap_interrupt_n,
    .mem_addr, .mem_rd, .mem_wr, .mem_be, .mem_wdata, .mem_rdata);
  pam_mem_model pam_mem_model_inst (.clk, .mem_rd, .mem_addr, .mem_rdata);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_fail++;
      final_report();
    end
  end
  // one control at a time keeps clear of conflicting combinations
  task automatic op(input logic [5:0] m, input logic [15:0] v, input int n);
    @(posedge clk);
    ctl_n  <= ~m;
    addr_i <= v;
    repeat (n) @(posedge clk);
    ctl_n  <= 6'h3f;
  endtask : op
  task automatic rb(input logic [5:0] m, input logic [15:0] e);
    op(m, 16'h0000, 1);
    #1;
    `CHK(addr_oe, 1'b1)
    `CHK(addr_o, e)
  endtask : rb
  task automatic rd(input logic [5:0] m, input logic [15:0] v, input logic [1:0] be,
                    input logic oe, input logic [1:0] eoe, input logic [15:0] ea);
    @(posedge clk);
    select_low_active  <= 1'b0;
    select_high_active <= 1'b1;
    be_n   <= be;
    ctl_n  <= ~m;
    addr_i <= v;
    @(posedge clk);
    select_low_active <= 1'b1;
    ctl_n <= 6'h3f;
    // word reaches the pins two edges after the sampled read
    repeat (2) @(posedge clk);
    // enable changes on the launching edge: a clocked gate would lag
    oe_n <= oe;
    #1;
    `CHK(dq_oe, eoe)
    if (eoe !== 2'b00) `CHK(dq_o, {2'b10, ea})
  endtask : rd
  task automatic t_walk();
    rb(CRB, 16'h0000);
    rb(MRB, 16'hffff);
    op(LD, 16'hfffe, 1);
    op(INC, 16'h0000, 2);
    #1;
    `CHK(wrap_interrupt_n, 1'b0)
    @(posedge clk);
    #1;
    `CHK(wrap_interrupt_n, 1'b1)
    rb(CRB, 16'h0000);
  endtask : t_walk
  task automatic t_mask();
    op(MLD, 16'h000f, 1);
    rb(MRB, 16'h000f);
    op(LD, 16'h012e, 1);
    rb(CRB, 16'h012e);
    op(INC, 16'h0000, 1);
    #1;
    `CHK(wrap_interrupt_n, 1'b1)
    op(INC, 16'h0000, 1);
    #1;
    `CHK(wrap_interrupt_n, 1'b0)
    rb(CRB, 16'h0120);
    op(CLR, 16'h0000, 1);
    rb(CRB, 16'h0000);
  endtask : t_mask
  task automatic t_read();
    op(LD, 16'h0040, 1);
    rb(CRB, 16'h0040);
    rd(CRB, 16'h0000, 2'b00, 1'b1, 2'b00, 16'h0040);
    rd(CRB, 16'h0000, 2'b00, 1'b0, 2'b11, 16'h0040);
    rd(MRB, 16'h0077, 2'b10, 1'b0, 2'b01, 16'h0077);
  endtask : t_read
  task automatic t_write();
    @(posedge clk);
    select_low_active <= 1'b0;
    read_write        <= 1'b0;
    be_n              <= 2'b01;
    dq_i              <= 18'h2_5a5a;
    @(posedge clk);
    select_low_active <= 1'b1;
    read_write        <= 1'b1;
    #1;
    `CHK({mem_wr, mem_be, mem_addr, mem_wdata}, {1'b1, 2'b10, 16'h0040, 18'h2_5a5a})
    @(posedge clk);
    #1;
    `CHK(mem_wr, 1'b0)
  endtask : t_write
  task automatic t_global();
    @(posedge clk);
    oe_n  <= 1'b1;
    ctl_n <= ~CRB;
    repeat (2) @(posedge clk);
    global_reset_n <= 1'b0;
    #1;
    `CHK(addr_oe, 1'b0)
    `CHK(wrap_interrupt_n, 1'b1)
    repeat (4) @(posedge clk);
    global_reset_n <= 1'b1;
    ctl_n <= 6'h3f;
    repeat (3) @(posedge clk);
    rb(MRB, 16'hffff);
    rb(CRB, 16'h0000);
  endtask : t_global
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_walk();
    t_mask();
    t_read();
    t_write();
    t_global();
    final_report();
  end
endmodule : tb_top
